// ===== include/fdc_map.svh
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// Page 2 image size
`define FDC_WORDS          16
`define FDC_IDX_W          4
`define FDC_WORD_W         14

// Signature register
`define FDC_SIG_W          16
`define FDC_SIG_POLY       16'h1021
`define FDC_SIG_SEED       16'hFFFF

// Fault summary layout
`define FDC_FLT_W          8
`define FDC_FLT_CKSUM_BIT  0
`define FDC_FLT_RESET      8'h00

`endif

// ===== include/fdc_pkg.sv
`include "fdc_map.svh"

package fdc_pkg;

   typedef struct packed {
      logic reset_cmd;
      logic check_sum;
      logic calc_sum;
   } fdc_cmd_t;

   typedef struct packed {
      logic [`FDC_SIG_W-1:0] ref_sig;
      logic [`FDC_SIG_W-1:0] calc_sig;
   } fdc_sig_t;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_CALC,
      ST_CHECK,
      ST_NV
   } fdc_state_t;

endpackage

// ===== verilog/fdc_unit.sv
`timescale 1ns/100ps
`include "fdc_map.svh"

// Notes on behaviour
// [R1] Unprompted summary send when summary was zero
// [R2] Host reads detail register only on fault
// [R3] Host clears detail bits before summary bits
// [R4] Host reference check read order A,B,C,scan,ref
// [R5] Calculate command stores page 2 checksum
// [R6] Host recalculates after every page 2 change
// [R7] Check command recomputes and compares stored
// [R8] Mismatch sets register checksum fault bit
// [R9] Host reloads page 2 after checksum fault
// [R10] Host verifies readback before new calculate
// [R11] Host clears summary bits after check
// [R12] Reference and computed signatures both readable
// [R13] Signature computed on power-up and reset command
// [R14] Host compares signatures, resets on mismatch
// [R15] Coefficient A is upper nine signed bits
// [R16] Host subtracts temperature adjustment from reference
// [R17] Deterministic shift register signature algorithm

module fdc_unit (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rstn,
   input  wire logic [`FDC_WORDS*`FDC_WORD_W-1:0]     cfg_regs,
   input  wire logic [`FDC_WORDS*`FDC_WORD_W-1:0]     nv_image,
   input  wire logic [`FDC_SIG_W-1:0]                 nv_ref_sig,
   input  wire fdc_pkg::fdc_cmd_t                     cmd,
   input  wire logic [`FDC_FLT_W-1:0]                 fault_set,
   input  wire logic [`FDC_FLT_W-1:0]                 fault_clr,
   output logic      [`FDC_FLT_W-1:0]                 fault_summary,
   output logic                                       status_send,
   output logic      [`FDC_FLT_W-1:0]                 status_word,
   output fdc_pkg::fdc_sig_t                          sigs,
   output logic                                       busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Signature step

   function automatic logic [`FDC_SIG_W-1:0] misr_step(
      input logic [`FDC_SIG_W-1:0]  s,
      input logic [`FDC_WORD_W-1:0] w
   );
      logic [`FDC_SIG_W-1:0] sh;
      sh = {s[`FDC_SIG_W-2:0], 1'b0} ^ (s[`FDC_SIG_W-1] ? `FDC_SIG_POLY : '0);
      return sh ^ {{(`FDC_SIG_W-`FDC_WORD_W){1'b0}}, w}; // R17
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   fdc_pkg::fdc_state_t             state_q;
   fdc_pkg::fdc_state_t             state_d;
   logic [`FDC_IDX_W-1:0]           idx_q;
   logic [`FDC_SIG_W-1:0]           acc_q;
   logic [`FDC_SIG_W-1:0]           stored_q;
   fdc_pkg::fdc_sig_t               sigs_q;
   logic [`FDC_FLT_W-1:0]           fault_sum_q;
   logic [`FDC_FLT_W-1:0]           fault_sum_d;
   logic                            send_q;
   logic [`FDC_FLT_W-1:0]           word_q;
   logic                            busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Word selection

   logic [`FDC_WORD_W-1:0]          cfg_w [`FDC_WORDS];
   logic [`FDC_WORD_W-1:0]          nv_w  [`FDC_WORDS];

   genvar gi;
   generate
      for (gi = 0; gi < `FDC_WORDS; gi++) begin : g_word
         assign cfg_w[gi] = cfg_regs[gi*`FDC_WORD_W +: `FDC_WORD_W];
         assign nv_w[gi]  = nv_image[gi*`FDC_WORD_W +: `FDC_WORD_W];
      end
   endgenerate

   wire                             in_nv     = (state_q == fdc_pkg::ST_NV);
   wire                             walking   = (state_q == fdc_pkg::ST_CALC) ||
                                                (state_q == fdc_pkg::ST_CHECK) || in_nv;
   wire [`FDC_WORD_W-1:0]           cur_word  = in_nv ? nv_w[idx_q] : cfg_w[idx_q];
   wire [`FDC_SIG_W-1:0]            acc_next  = misr_step(acc_q, cur_word);
   wire                             last_word = (idx_q == `FDC_IDX_W'(`FDC_WORDS-1));
   wire                             done      = walking && last_word;
   wire                             idle      = (state_q == fdc_pkg::ST_IDLE);
   wire                             go_nv     = (state_q == fdc_pkg::ST_BOOT) ||
                                                (idle && cmd.reset_cmd);          // R13
   wire                             go_check  = idle && !cmd.reset_cmd && cmd.check_sum;
   wire                             go_calc   = idle && !cmd.reset_cmd && !cmd.check_sum &&
                                                cmd.calc_sum;
   wire                             starting  = go_nv || go_check || go_calc;
   wire                             in_calc   = (state_q == fdc_pkg::ST_CALC);
   wire                             in_check  = (state_q == fdc_pkg::ST_CHECK);
   wire                             calc_done = done && in_calc;
   wire                             cmp_done  = done && in_check;
   wire                             nv_done   = done && in_nv;

   wire                             chk_fail  = cmp_done && (acc_next != stored_q);   // R7
   wire [`FDC_FLT_W-1:0]            fail_vec  = chk_fail ?
                                                (`FDC_FLT_W'(1) << `FDC_FLT_CKSUM_BIT) : '0;
   wire [`FDC_FLT_W-1:0]            set_all   = fault_set | fail_vec;             // R8
   wire                             sum_zero  = (fault_sum_q == '0);
   wire                             any_set   = (set_all != '0);
   wire                             auto_send = sum_zero && any_set;              // R1

   ////////////////////////////////////////////////////////////////////////////
   // Fault summary bits, set wins over clear

   genvar fb;
   generate
      for (fb = 0; fb < `FDC_FLT_W; fb++) begin : g_flt
         assign fault_sum_d[fb] = set_all[fb] | (fault_sum_q[fb] & ~fault_clr[fb]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next register values

   logic [`FDC_IDX_W-1:0]           idx_d;
   logic [`FDC_SIG_W-1:0]           acc_d;
   logic                            busy_d;
   logic [`FDC_SIG_W-1:0]           stored_d;
   logic [`FDC_SIG_W-1:0]           ref_sig_d;
   logic [`FDC_SIG_W-1:0]           calc_sig_d;
   logic                            send_d;
   logic [`FDC_FLT_W-1:0]           word_d;

   assign idx_d      = walking ? idx_q + `FDC_IDX_W'(1) : '0;
   assign acc_d      = (walking && !done) ? acc_next : `FDC_SIG_SEED;
   assign busy_d     = starting || (walking && !last_word);

   assign stored_d   = calc_done ? acc_next : stored_q;                         // R5
   assign ref_sig_d  = go_nv ? nv_ref_sig : sigs_q.ref_sig;                     // R12
   assign calc_sig_d = nv_done ? acc_next : sigs_q.calc_sig;                    // R12
   assign send_d     = auto_send;                                               // R1
   assign word_d     = auto_send ? fault_sum_d : word_q;                        // R1

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_d = state_q;
      case (state_q)
         fdc_pkg::ST_BOOT: begin
            state_d = fdc_pkg::ST_NV;                                              // R13
         end
         fdc_pkg::ST_IDLE: begin
            if (go_nv) begin
               state_d = fdc_pkg::ST_NV;
            end else if (go_check) begin
               state_d = fdc_pkg::ST_CHECK;
            end else if (go_calc) begin
               state_d = fdc_pkg::ST_CALC;
            end
         end
         fdc_pkg::ST_CALC,
         fdc_pkg::ST_CHECK,
         fdc_pkg::ST_NV: begin
            if (last_word) begin
               state_d = fdc_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = fdc_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Walk over words

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_q <= fdc_pkg::ST_BOOT;
         idx_q   <= '0;
         acc_q   <= `FDC_SIG_SEED;
         busy_q  <= 1'b1;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
         acc_q   <= acc_d;
         busy_q  <= busy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stored checksum and signatures

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stored_q <= `FDC_SIG_SEED;
         sigs_q   <= '0;
      end else begin
         stored_q        <= stored_d;
         sigs_q.ref_sig  <= ref_sig_d;
         sigs_q.calc_sig <= calc_sig_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault summary and unprompted send

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fault_sum_q <= `FDC_FLT_RESET;
         send_q      <= 1'b0;
         word_q      <= '0;
      end else begin
         fault_sum_q <= fault_sum_d;
         send_q      <= send_d;
         word_q      <= word_d;
      end
   end

   assign fault_summary = fault_sum_q;
   assign status_send   = send_q;
   assign status_word   = word_q;
   assign sigs          = sigs_q;
   assign busy          = busy_q;

endmodule

// ===== sim/fdc_unit_chk.sv
`timescale 1ns/100ps
module fdc_unit_chk (
   input wire logic              clk_sys,
   input wire logic              rstn,
   input wire fdc_pkg::fdc_cmd_t cmd,
   input wire logic [7:0]        fault_set,
   input wire logic [7:0]        fault_clr,
   input wire logic [7:0]        fault_summary,
   input wire logic              status_send,
   input wire logic [7:0]        status_word,
   input wire logic              busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_send_from_zero: assert property (status_send |-> $past(fault_summary) == 8'h00)
      else $error("send without zero summary");
   chk_send_word_match: assert property (status_send |-> status_word == fault_summary)
      else $error("sent word differs");
   chk_send_needed: assert property (fault_summary == 8'h00 && fault_set != 8'h00 |=>
      status_send)
      else $error("send missing");
   chk_no_send_nonzero: assert property (fault_summary != 8'h00 |=> !status_send)
      else $error("send on nonzero summary");
   chk_set_bits_land: assert property (fault_set != 8'h00 |=>
      (fault_summary & $past(fault_set)) == $past(fault_set))
      else $error("set bit lost");
   chk_clear_bits_land: assert property (fault_clr != 8'h00 && fault_set == 8'h00 &&
      !busy |=> (fault_summary & $past(fault_clr)) == 8'h00)
      else $error("clear bit stuck");
   chk_walk_length: assert property (!busy && cmd != 3'h0 |=>
      busy [*8] ##8 busy ##1 !busy)
      else $error("walk length wrong");
   chk_flag_cause: assert property ($rose(fault_summary[0]) |->
      $past(fault_set[0]) || $past(busy))
      else $error("checksum flag without cause");
endmodule
bind fdc_unit fdc_unit_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .cmd(cmd),
   .fault_set(fault_set), .fault_clr(fault_clr), .fault_summary(fault_summary),
   .status_send(status_send), .status_word(status_word), .busy(busy));

// ===== sim/fdc_host.sv
`timescale 1ns/100ps
module fdc_host (
   input  wire logic        clk_sys,
   input  wire logic        busy,
   output fdc_pkg::fdc_cmd_t cmd,
   output logic [7:0]       fault_clr
);
   initial begin
      cmd = 3'h0;
      fault_clr = 8'h00;
   end
   // One command, only once idle
   task automatic issue(input fdc_pkg::fdc_cmd_t c, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge clk_sys);
         #1 ok = (busy === 1'b0);
      end
      if (ok) cmd = c;
      @(posedge clk_sys);
      #1 cmd = 3'h0;
   endtask
   // Summary bits cleared last
   task automatic clear(input logic [7:0] m);
      fault_clr = m;
      @(posedge clk_sys);
      #1 fault_clr = 8'h00;
   endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic              clk_sys, rstn, status_send, busy;
   logic [223:0]      cfg_regs, nv_image;
   logic [15:0]       nv_ref_sig;
   logic [7:0]        fault_set, fault_clr, fault_summary, status_word;
   fdc_pkg::fdc_cmd_t cmd;
   fdc_pkg::fdc_sig_t sigs;
   bit                ok;
   int                errors, total_checks;
   fdc_host host (.clk_sys(clk_sys), .busy(busy), .cmd(cmd), .fault_clr(fault_clr));
   fdc_unit DUT (.clk_sys(clk_sys), .rstn(rstn), .cfg_regs(cfg_regs), .nv_image(nv_image),
      .nv_ref_sig(nv_ref_sig), .cmd(cmd), .fault_set(fault_set), .fault_clr(fault_clr),
      .fault_summary(fault_summary), .status_send(status_send), .status_word(status_word),
      .sigs(sigs), .busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] misr(input logic [223:0] img);
      logic [15:0] s;
      s = 16'hFFFF;
      for (int i = 0; i < 16; i++)
         s = {s[14:0], 1'b0} ^ (s[15] ? 16'h1021 : 16'h0000) ^ {2'b00, img[i*14 +: 14]};
      return s;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (busy !== 1'b0) begin
         errors++;
         finish_test;
      end
   endtask
   task automatic run(input fdc_pkg::fdc_cmd_t c);
      host.issue(c, ok);
      if (!ok) begin
         errors++;
         finish_test;
      end
      wait_idle;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_boot;
      wait_idle;
      check(sigs, {nv_ref_sig, misr(nv_image)});
   endtask
   task automatic t_checksum;
      run(3'b001);
      run(3'b010);
      check({status_send, fault_summary}, 9'h000);
      cfg_regs[20] = ~cfg_regs[20];
      run(3'b010);
      check({status_send, status_word, fault_summary}, {1'b1, 16'h0101});
      host.clear(8'h01);
      check(fault_summary, 8'h00);
      cfg_regs[20] = ~cfg_regs[20];
      run(3'h1);
      run(3'h2);
      check(fault_summary, 8'h00);
   endtask
   task automatic t_events;
      fault_set = 8'h04;
      @(posedge clk_sys);
      #1 check({status_send, status_word, fault_summary}, {1'b1, 16'h0404});
      fault_set = 8'h10;
      @(posedge clk_sys);
      #1 check({status_send, fault_summary}, 9'h014);
      fault_set = 8'h00;
      host.clear(8'h14);
      check(fault_summary, 8'h00);
   endtask
   task automatic t_reload;
      nv_image = {16{14'h2A5C}};
      nv_ref_sig = 16'h3C96;
      run(3'b100);
      check(sigs, {16'h3C96, misr(nv_image)});
      if (sigs.ref_sig !== sigs.calc_sig) begin
         run(3'h4);
         check(sigs, {16'h3C96, misr(nv_image)});
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      rstn = 1'b0;
      cfg_regs = {16{14'h1357}};
      nv_image = {16{14'h0F0F}};
      nv_ref_sig = 16'hA55A;
      fault_set = 8'h00;
      repeat (3) @(posedge clk_sys);
      #1 rstn = 1'b1;
      t_boot;
      t_checksum;
      t_events;
      t_reload;
      finish_test;
   end
endmodule
